// file: verilog/pin_remap_pkg.sv
// Constants, register map and carrier types for the pin remap and port block
package pin_remap_pkg;

  localparam int NUM_PORTS = 5;
  localparam int NUM_TOUT  = 8;

  typedef logic [7:0]                 byte_t;
  typedef logic [NUM_PORTS-1:0][7:0]  port_vec_t;
  typedef logic [2:0]                 port_idx_t;

  // ==========================================================
  // Port indices
  localparam port_idx_t PORT_A = 3'h0;
  localparam port_idx_t PORT_B = 3'h1;
  localparam port_idx_t PORT_C = 3'h2;
  localparam port_idx_t PORT_D = 3'h3;
  localparam port_idx_t PORT_E = 3'h4;

  // ==========================================================
  // Register offsets
  localparam byte_t OFS_INPUT_REMAP = 8'h00;
  localparam byte_t OFS_TOUT_REMAP  = 8'h01;
  localparam byte_t OFS_LCD_REMAP   = 8'h02;
  localparam byte_t OFS_WAKE_EN     = 8'h03;
  localparam byte_t OFS_BIT_OP      = 8'h04;
  localparam byte_t OFS_DATA_BASE   = 8'h08;
  localparam byte_t OFS_DIR_BASE    = 8'h10;

  // ==========================================================
  // Reset values and implemented-bit masks
  localparam byte_t RST_REMAP        = 8'h00;
  localparam byte_t RST_PORT         = 8'hFF;
  localparam byte_t RST_WAKE_EN      = 8'h00;
  localparam byte_t MASK_INPUT_LARGE = 8'hFF;
  localparam byte_t MASK_INPUT_SMALL = 8'hF5;
  localparam byte_t MASK_TOUT_LARGE  = 8'hFF;
  localparam byte_t MASK_TOUT_SMALL  = 8'hB3;
  localparam byte_t TOUT_HAS_SMALL   = 8'hF3;
  localparam byte_t MASK_LCD_LARGE   = 8'hBF;
  localparam byte_t MASK_LCD_SMALL   = 8'h3F;

  // ==========================================================
  // Field positions
  localparam int IN_IRQ1_BIT  = 7;
  localparam int IN_IRQ0_BIT  = 6;
  localparam int IN_TIMER1_CLOCK_INPUT_BIT  = 5;
  localparam int IN_TIMER0_CLOCK_INPUT_BIT  = 4;
  localparam int IN_PERIPHERAL_IRQ_PIN_LSB  = 2;
  localparam int IN_PCK_LSB   = 0;
  localparam int LCD_TIMER2_CLOCK_INPUT_BIT = 7;
  localparam int BOP_VAL_BIT  = 7;
  localparam int BOP_PORT_LSB = 4;
  localparam int BOP_DIR_BIT  = 3;
  localparam int BOP_BIT_LSB  = 0;

  // ==========================================================
  // Timer output routing, index i is select bit i of the output remap register
  localparam port_idx_t TOUT_PORT_LO [NUM_TOUT] = '{PORT_B, PORT_B, PORT_B, PORT_B,
                                                    PORT_B, PORT_B, PORT_B, PORT_B};
  localparam logic [2:0] TOUT_BIT_LO [NUM_TOUT] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h5, 3'h2, 3'h3, 3'h4};
  localparam port_idx_t TOUT_PORT_HI [NUM_TOUT] = '{PORT_C, PORT_C, PORT_E, PORT_E,
                                                    PORT_C, PORT_C, PORT_C, PORT_C};
  localparam logic [2:0] TOUT_BIT_HI [NUM_TOUT] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h5, 3'h2, 3'h3, 3'h4};

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [NUM_TOUT-1:0] level;
    logic [NUM_TOUT-1:0] enable;
  } tmr_out_s;

  typedef struct packed {
    logic external_irq_1;
    logic external_irq_0;
    logic peripheral_irq_pin;
    logic timer2_clock_input;
    logic timer1_clock_input;
    logic timer0_clock_input;
  } fn_in_s;

endpackage

// file: verilog/pin_remap_port.sv
// Pin remap multiplexer with port data, direction, bit operations and port A wake-up
// Operation
// - Both variants: bit1 moves timer0 out1 B1 to C1
// - Bit7 moves timer1 B out2 B4 to C4
// - Large: bit6 moves timer1 B out1 B3 to C3
// - Bit5 moves timer1 B out0 B2 to C2
// - Bit4 moves timer1 A output B5 to C5
// - Large: bit3 moves timer2 out1 B2 to E2
// - Large: bit2 moves timer2 out0 B1 to E1
// - Bit1 moves timer0 out1 B1 to C1
// - Bit0 moves timer0 out0 B0 to C0
// - Large: LCD register bit7 picks timer2 clock C6/D0
// - LCD register bit6 ignores writes, reads zero
// - Reset sets all data and direction ones
// - Direction bit high means pin is input
// - New output drives held data, high after reset
// - Bit operation reads port, modifies, writes back
// - Enabled port A falling edge wakes sleep
// - Each port A pin wake enabled separately
`timescale 1ns/10ps

module pin_remap_port #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire pin_remap_pkg::byte_t     addr_i,
  input  wire pin_remap_pkg::byte_t     wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic [7:0]                    rdata_o,
  input  wire pin_remap_pkg::port_vec_t pin_in_i,
  output pin_remap_pkg::port_vec_t      pin_out_o,
  output pin_remap_pkg::port_vec_t      pin_oe_o,
  input  wire pin_remap_pkg::tmr_out_s  tmr_out_i,
  input  wire logic                     pck_i,
  input  wire logic                     pck_en_i,
  input  wire logic                     sleep_i,
  output logic                          wake_o,
  output pin_remap_pkg::fn_in_s         fn_in_o
);
  import pin_remap_pkg::*;

  // ==========================================================
  // Decoding helpers
  // Two-bit location code to one-hot of three places; code 11 selects nothing
  function automatic logic [2:0] loc3(input logic [1:0] code);
    logic [2:0] hot;
    hot = 3'h0;
    if (code == 2'h0)
      hot = 3'h1;
    else if (code == 2'h1)
      hot = 3'h2;
    else if (code == 2'h2)
      hot = 3'h4;
    return hot;
  endfunction

  function automatic logic ofs_in(input byte_t a, input byte_t base);
    return (a >= base) && (a < base + byte_t'(NUM_PORTS));
  endfunction

  // ==========================================================
  // Register state
  byte_t      input_remap_q;
  byte_t      tout_remap_q;
  byte_t      lcd_remap_q;
  byte_t      wake_en_q;
  port_vec_t  data_q;
  port_vec_t  data_d;
  port_vec_t  dir_q;
  port_vec_t  dir_d;
  port_vec_t  pin_out_q;
  port_vec_t  pin_oe_q;
  port_vec_t  out_d;
  port_vec_t  oe_d;
  byte_t      rdata_q;
  byte_t      rdata_d;
  byte_t      pa_prev_q;
  logic       wake_q;
  fn_in_s     fn_in_q;
  fn_in_s     fn_in_d;

  // ==========================================================
  // Variant masks
  wire byte_t mask_input = LARGE_VARIANT ? MASK_INPUT_LARGE : MASK_INPUT_SMALL;
  wire byte_t mask_tout  = LARGE_VARIANT ? MASK_TOUT_LARGE : MASK_TOUT_SMALL;
  wire byte_t mask_lcd   = LARGE_VARIANT ? MASK_LCD_LARGE : MASK_LCD_SMALL;
  wire byte_t tout_has   = LARGE_VARIANT ? 8'hFF : TOUT_HAS_SMALL;

  // ==========================================================
  // Address decode
  wire logic      wr_input  = wr_i && (addr_i == OFS_INPUT_REMAP);
  wire logic      wr_tout   = wr_i && (addr_i == OFS_TOUT_REMAP);
  wire logic      wr_lcd    = wr_i && (addr_i == OFS_LCD_REMAP);
  wire logic      wr_wake   = wr_i && (addr_i == OFS_WAKE_EN);
  wire logic      wr_bitop  = wr_i && (addr_i == OFS_BIT_OP);
  wire logic      hit_data  = ofs_in(addr_i, OFS_DATA_BASE);
  wire logic      hit_dir   = ofs_in(addr_i, OFS_DIR_BASE);
  wire port_idx_t data_idx  = port_idx_t'(addr_i - OFS_DATA_BASE);
  wire port_idx_t dir_idx   = port_idx_t'(addr_i - OFS_DIR_BASE);

  // ==========================================================
  // Port readback: input pins show the pin level, output pins the latch
  port_vec_t port_rb;
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_rb
      assign port_rb[gp] = (dir_q[gp] & pin_in_i[gp]) | (~dir_q[gp] & data_q[gp]);
    end
  endgenerate

  // ==========================================================
  // Single-bit operation: whole port is read, one bit changed, whole byte written back
  wire logic      bop_val    = wdata_i[BOP_VAL_BIT];
  wire port_idx_t bop_port   = wdata_i[BOP_PORT_LSB +: 3];
  wire logic      bop_is_dir = wdata_i[BOP_DIR_BIT];
  wire logic [2:0] bop_bit   = wdata_i[BOP_BIT_LSB +: 3];
  wire logic      bop_ok     = wr_bitop && (bop_port < port_idx_t'(NUM_PORTS));
  wire byte_t     bop_src    = bop_is_dir ? dir_q[bop_port] : port_rb[bop_port];
  byte_t          bop_new;

  always_comb
  begin
    bop_new          = bop_src;
    bop_new[bop_bit] = bop_val;
  end

  // Byte writes and bit operations never coincide since a strobe carries one address
  always_comb
  begin
    data_d = data_q;
    dir_d  = dir_q;
    if (wr_i && hit_data)
      data_d[data_idx] = wdata_i;
    if (wr_i && hit_dir)
      dir_d[dir_idx] = wdata_i;
    if (bop_ok && !bop_is_dir)
      data_d[bop_port] = bop_new;
    if (bop_ok && bop_is_dir)
      dir_d[bop_port] = bop_new;
  end

  // ==========================================================
  // Read mux
  always_comb
  begin
    rdata_d = 8'h00;
    if (addr_i == OFS_INPUT_REMAP)
      rdata_d = input_remap_q;
    else if (addr_i == OFS_TOUT_REMAP)
      rdata_d = tout_remap_q;
    else if (addr_i == OFS_LCD_REMAP)
      rdata_d = lcd_remap_q;
    else if (addr_i == OFS_WAKE_EN)
      rdata_d = wake_en_q;
    else if (hit_data)
      rdata_d = port_rb[data_idx];
    else if (hit_dir)
      rdata_d = dir_q[dir_idx];
  end

  // ==========================================================
  // Pin drive: port latch first, then routed timer and peripheral clock outputs
  // Later overlays win when two functions land on one pin; software must avoid that
  wire logic [2:0] pck_hot  = loc3(input_remap_q[IN_PCK_LSB +: 2]);
  wire logic [2:0] peripheral_irq_pin_hot = loc3(input_remap_q[IN_PERIPHERAL_IRQ_PIN_LSB +: 2]);

  always_comb
  begin
    out_d = data_q;
    oe_d  = ~dir_q;
    for (int i = 0; i < NUM_TOUT; i++)
    begin
      if (tmr_out_i.enable[i] && tout_has[i])
      begin
        if (tout_remap_q[i])
        begin
          out_d[TOUT_PORT_HI[i]][TOUT_BIT_HI[i]] = tmr_out_i.level[i];
          oe_d[TOUT_PORT_HI[i]][TOUT_BIT_HI[i]]  = 1'b1;
        end
        else
        begin
          out_d[TOUT_PORT_LO[i]][TOUT_BIT_LO[i]] = tmr_out_i.level[i];
          oe_d[TOUT_PORT_LO[i]][TOUT_BIT_LO[i]]  = 1'b1;
        end
      end
    end
    if (pck_en_i && pck_hot[0])
    begin
      out_d[PORT_B][4] = pck_i;
      oe_d[PORT_B][4]  = 1'b1;
    end
    if (pck_en_i && pck_hot[1])
    begin
      out_d[PORT_C][6] = pck_i;
      oe_d[PORT_C][6]  = 1'b1;
    end
    if (pck_en_i && pck_hot[2])
    begin
      out_d[PORT_E][1] = pck_i;
      oe_d[PORT_E][1]  = 1'b1;
    end
  end

  // ==========================================================
  // Input routing to interrupt and timer clock logic
  always_comb
  begin
    fn_in_d = '0;
    fn_in_d.external_irq_1     = input_remap_q[IN_IRQ1_BIT] ? pin_in_i[PORT_C][5] : pin_in_i[PORT_A][1];
    fn_in_d.external_irq_0     = input_remap_q[IN_IRQ0_BIT] ? pin_in_i[PORT_C][4] : pin_in_i[PORT_A][4];
    fn_in_d.timer1_clock_input = input_remap_q[IN_TIMER1_CLOCK_INPUT_BIT] ? pin_in_i[PORT_C][5] : pin_in_i[PORT_A][1];
    fn_in_d.timer0_clock_input = input_remap_q[IN_TIMER0_CLOCK_INPUT_BIT] ? pin_in_i[PORT_C][4] : pin_in_i[PORT_A][4];
    fn_in_d.peripheral_irq_pin = (peripheral_irq_pin_hot[0] & pin_in_i[PORT_B][5])
                               | (peripheral_irq_pin_hot[1] & pin_in_i[PORT_C][7])
                               | (peripheral_irq_pin_hot[2] & pin_in_i[PORT_E][0]);
    if (LARGE_VARIANT)
      fn_in_d.timer2_clock_input = lcd_remap_q[LCD_TIMER2_CLOCK_INPUT_BIT] ? pin_in_i[PORT_D][0] : pin_in_i[PORT_C][6];
  end

  // ==========================================================
  // Wake-up: falling edge on an enabled port A pin while asleep (sleep_i high)
  wire byte_t pa_fall  = pa_prev_q & ~pin_in_i[PORT_A];
  wire logic  wake_d   = sleep_i && |(pa_fall & wake_en_q);

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      input_remap_q <= RST_REMAP;
      tout_remap_q  <= RST_REMAP;
      lcd_remap_q   <= RST_REMAP;
      wake_en_q     <= RST_WAKE_EN;
    end
    else
    begin
      if (wr_input)
        input_remap_q <= wdata_i & mask_input;
      if (wr_tout)
        tout_remap_q <= wdata_i & mask_tout;
      if (wr_lcd)
        lcd_remap_q <= wdata_i & mask_lcd;
      if (wr_wake)
        wake_en_q <= wdata_i;
    end
  end

  // ==========================================================
  // Port registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      data_q <= {NUM_PORTS{RST_PORT}};
      dir_q  <= {NUM_PORTS{RST_PORT}};
    end
    else
    begin
      data_q <= data_d;
      dir_q  <= dir_d;
    end
  end

  // ==========================================================
  // Output stage
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_out_q <= {NUM_PORTS{RST_PORT}};
      pin_oe_q  <= '0;
      rdata_q   <= 8'h00;
      pa_prev_q <= RST_PORT;
      wake_q    <= 1'b0;
      fn_in_q   <= '0;
    end
    else
    begin
      pin_out_q <= out_d;
      pin_oe_q  <= oe_d;
      rdata_q   <= rd_i ? rdata_d : 8'h00;
      pa_prev_q <= pin_in_i[PORT_A];
      wake_q    <= wake_d;
      fn_in_q   <= fn_in_d;
    end
  end

  assign rdata_o   = rdata_q;
  assign pin_out_o = pin_out_q;
  assign pin_oe_o  = pin_oe_q;
  assign wake_o    = wake_q;
  assign fn_in_o   = fn_in_q;

endmodule

// file: bench/pin_ext_model.sv
// Board circuitry model sitting on the shared port pins
`timescale 1ns/10ps
module pin_ext_model (
  input  wire pin_remap_pkg::port_vec_t pin_out_i,
  input  wire pin_remap_pkg::port_vec_t pin_oe_i,
  input  wire pin_remap_pkg::port_vec_t ext_i,
  output pin_remap_pkg::port_vec_t      pin_o
);
  import pin_remap_pkg::*;
  // ==========================================================
  // Pin levels
  // Undriven pins follow the board, so input levels come from outside
  assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule

// file: bench/pin_remap_checker.sv
// Port level assertions for the pin remap and port block
`timescale 1ns/10ps
module pin_remap_checker
  import pin_remap_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic      clk_i,
  input wire logic      rst_n_i,
  input wire byte_t     addr_i,
  input wire byte_t     wdata_i,
  input wire logic      wr_i,
  input wire logic      rd_i,
  input wire logic [7:0] rdata_o,
  input wire port_vec_t pin_in_i,
  input wire port_vec_t pin_out_o,
  input wire port_vec_t pin_oe_o,
  input wire tmr_out_s  tmr_out_i,
  input wire logic      pck_i,
  input wire logic      pck_en_i,
  input wire logic      sleep_i,
  input wire logic      wake_o,
  input wire fn_in_s    fn_in_o
);
  // ==========================================================
  // Shadow copies of the select registers
  byte_t inp_q;
  byte_t wen_q;
  logic  t00_q;
  wire   irq1_v = inp_q[7] ? pin_in_i[PORT_C][5] : pin_in_i[PORT_A][1];
  wire   pck_v  = pck_en_i && inp_q[1:0] == 2'h1;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      inp_q <= 8'h00;
      wen_q <= 8'h00;
      t00_q <= 1'b0;
    end
    else if (wr_i)
    begin
      if (addr_i == OFS_INPUT_REMAP) inp_q <= wdata_i & (LARGE_VARIANT ? 8'hFF : 8'hF5);
      if (addr_i == OFS_TOUT_REMAP) t00_q <= wdata_i[0];
      if (addr_i == OFS_WAKE_EN) wen_q <= wdata_i;
    end
  end
  property p_rst;
    $rose(rst_n_i) |-> pin_oe_o == '0 && pin_out_o == {NUM_PORTS{8'hFF}};
  endproperty
  a_rst: assert property (p_rst) else $error("pins not idle");
  property p_lcd;
    rd_i && addr_i == OFS_LCD_REMAP |=> rdata_o[6] == 1'b0;
  endproperty
  a_lcd: assert property (p_lcd) else $error("bit 6 set");
  property p_inp;
    rd_i && addr_i == OFS_INPUT_REMAP |=> rdata_o == $past(inp_q);
  endproperty
  a_inp: assert property (p_inp) else $error("remap readback");
  property p_irq;
    $past(rst_n_i) |-> fn_in_o.external_irq_1 == $past(irq1_v);
  endproperty
  a_irq: assert property (p_irq) else $error("irq1 route");
  property p_pck;
    $past(pck_v) |-> pin_oe_o[PORT_C][6] && pin_out_o[PORT_C][6] == $past(pck_i);
  endproperty
  a_pck: assert property (p_pck) else $error("clock pin route");
  property p_t00;
    $past(tmr_out_i.enable[0]) |-> pin_oe_o[$past(t00_q) ? PORT_C : PORT_B][0]
      && pin_out_o[$past(t00_q) ? PORT_C : PORT_B][0] == $past(tmr_out_i.level[0]);
  endproperty
  a_t00: assert property (p_t00) else $error("timer0 out route");
  property p_wake;
    sleep_i && |(wen_q & $past(pin_in_i[PORT_A]) & ~pin_in_i[PORT_A]) |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("missed wake");
  property p_wk2;
    wake_o |-> $past(sleep_i) && $past(wen_q) != 8'h00;
  endproperty
  a_wk2: assert property (p_wk2) else $error("stray wake");
  c_wake: cover property (wake_o);
  c_pck: cover property (pck_v);
  c_t00: cover property (tmr_out_i.enable[0] && t00_q);
endmodule
bind pin_remap_port pin_remap_checker #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (.*);

// file: bench/peripheral_pin_remap_and_port_init_tb.sv
// Self-checking bench for the pin remap and port block
`timescale 1ns/10ps
module peripheral_pin_remap_and_port_init_tb;
  import pin_remap_pkg::*;
  localparam byte_t DATA_D = OFS_DATA_BASE + 8'h03;
  localparam byte_t DIR_D  = OFS_DIR_BASE + 8'h03;
  logic       clk_i, rst_n_i, wr_i, rd_i, pck_i, pck_en_i, sleep_i, wake_o;
  byte_t      addr_i, wdata_i;
  logic [7:0] rdata_o;
  port_vec_t  pin_in_i, pin_out_o, pin_oe_o, ext;
  tmr_out_s   tmr_out_i;
  fn_in_s     fn_in_o;
  logic [7:0] rdata_s;
  port_vec_t  out_s, oe_s;
  int         err_count, compares, cyc, wake_n;
  // Timer output i sits on port B bit pos[i] or moves to port hi_p[i]
  port_idx_t  hi_p [8] = '{PORT_C, PORT_C, PORT_E, PORT_E, PORT_C, PORT_C, PORT_C, PORT_C};
  logic [2:0] pos [8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h5, 3'h2, 3'h3, 3'h4};
  logic [8:0] wk [6] = '{9'h1FF, 9'h1F7, 9'h1F3, 9'h1F2, 9'h0FF, 9'h0FA};
  pin_remap_port u_dut (.*);
  // Smaller variant shares the bus and pins so its masks and routing are checked alongside
  pin_remap_port #(.LARGE_VARIANT(1'b0)) u_dut_small (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o(rdata_s), .pin_in_i, .pin_out_o(out_s), .pin_oe_o(oe_s), .tmr_out_i, .pck_i, .pck_en_i,
    .sleep_i, .wake_o(), .fn_in_o());
  pin_ext_model u_ext (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_i(ext), .pin_o(pin_in_i));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ==========================================================
  // Tasks
  task automatic results;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (wake_o === 1'b1) wake_n++;
    if (cyc == 6000)
    begin
      err_count++;
      results();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input byte_t a, input byte_t d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input byte_t a, input byte_t exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  initial
  begin
    {rst_n_i, wr_i, rd_i, pck_i, pck_en_i, sleep_i} = '0;
    addr_i = '0;
    wdata_i = '0;
    tmr_out_i = '0;
    ext = '1;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 4; a++) rd(byte_t'(a), 8'h00);
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      rd(byte_t'(OFS_DATA_BASE + p), 8'hFF);
      rd(byte_t'(OFS_DIR_BASE + p), 8'hFF);
    end
    wr(OFS_LCD_REMAP, 8'hFF);
    rd(OFS_LCD_REMAP, 8'hBF);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    ext[PORT_D] <= 8'h00;
    wr(DIR_D, 8'h0F);
    settle();
    chk(pin_oe_o[PORT_D], 8'hF0);
    chk(pin_out_o[PORT_D] & 8'hF0, 8'hF0);
    // Clearing bit 7 copies the low input pins into the latch
    wr(OFS_BIT_OP, 8'h37);
    rd(DATA_D, 8'h70);
    wr(DIR_D, 8'h00);
    settle();
    chk(pin_out_o[PORT_D], 8'h70);
    wr(OFS_BIT_OP, 8'hBC);
    settle();
    chk(pin_oe_o[PORT_D], 8'hEF);
    @(posedge clk_i);
    {ext[PORT_A], ext[PORT_B], ext[PORT_C], ext[PORT_E]} <= 32'h0220_5001;
    pck_en_i <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_INPUT_REMAP, {{4{k[0]}}, k[1:0], k[1:0]});
      settle();
      chk({4'h0, fn_in_o.external_irq_1, fn_in_o.external_irq_0, fn_in_o.timer1_clock_input,
           fn_in_o.timer0_clock_input}, k[0] ? 8'h05 : 8'h0A);
      chk({7'h0, fn_in_o.peripheral_irq_pin}, {7'h0, k == 0 || k == 2});
      chk({5'h0, pin_oe_o[PORT_B][4], pin_oe_o[PORT_C][6], pin_oe_o[PORT_E][1]}, 8'h04 >> k);
      chk({5'h0, pin_out_o[PORT_B][4], pin_out_o[PORT_C][6], pin_out_o[PORT_E][1]}, 8'h07 ^ (8'h04 >> k));
    end
    pck_en_i <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      tmr_out_i <= {8'h00, 8'h01 << i};
      wr(OFS_TOUT_REMAP, 8'h00);
      settle();
      chk({6'h0, pin_oe_o[PORT_B][pos[i]], pin_out_o[PORT_B][pos[i]]}, 8'h02);
      wr(OFS_TOUT_REMAP, 8'h01 << i);
      settle();
      chk({6'h0, pin_oe_o[hi_p[i]][pos[i]], pin_out_o[hi_p[i]][pos[i]]}, 8'h02);
      chk({7'h0, pin_oe_o[PORT_B][pos[i]]}, 8'h00);
    end
    tmr_out_i <= {8'h00, 8'h02};
    wr(OFS_TOUT_REMAP, 8'hFF);
    rd(OFS_TOUT_REMAP, 8'hFF);
    chk(rdata_s, 8'hB3);
    settle();
    chk({7'h0, oe_s[PORT_C][1]}, 8'h01);
    chk({7'h0, oe_s[PORT_B][1]}, 8'h00);
    tmr_out_i <= '0;
    wr(OFS_LCD_REMAP, 8'h00);
    settle();
    chk({7'h0, fn_in_o.timer2_clock_input}, 8'h01);
    wr(OFS_LCD_REMAP, 8'h80);
    settle();
    chk({7'h0, fn_in_o.timer2_clock_input}, 8'h00);
    wr(OFS_WAKE_EN, 8'h05);
    for (int s = 0; s < 6; s++)
    begin
      @(posedge clk_i);
      {sleep_i, ext[PORT_A]} <= wk[s];
      settle();
    end
    chk(8'(wake_n), 8'h02);
    results();
  end
endmodule
